// ---- rtl/swocc_pkg.sv ----
// Constants for the selective wake oscillator trim and recovery configuration registers
package swocc_pkg;
   // Register addresses on the 7-bit command address
   localparam logic [6:0] SWOCC_ADDR_TRIM_FINE = 7'h38;
   localparam logic [6:0] SWOCC_ADDR_OPTIONS = 7'h39;
   localparam logic [6:0] SWOCC_ADDR_CALIB_HIGH = 7'h3a;
   localparam logic [6:0] SWOCC_ADDR_CALIB_LOW = 7'h3b;
   localparam logic [6:0] SWOCC_ADDR_CTRL_ONE = 7'h3c;
   localparam logic [6:0] SWOCC_ADDR_CTRL_TWO = 7'h3d;
   // Key value that unlocks the trim fields
   localparam logic [1:0] SWOCC_TRIM_KEY = 2'h3;
   // Field positions
   localparam int SWOCC_OPT_RXSEL_BIT = 7;
   localparam int SWOCC_OPT_COARSE_MSB = 4;
   localparam int SWOCC_FINE_MSB = 4;
   localparam int SWOCC_C1_FILT_LSB = 2;
   localparam int SWOCC_C1_EN_BIT = 0;
   // Writable masks; every other bit is reserved and reads zero
   localparam logic [7:0] SWOCC_OPT_MASK = 8'h9f;
   localparam logic [7:0] SWOCC_C1_MASK = 8'h0d;
   localparam logic [7:0] SWOCC_C2_MASK = 8'h03;
   // Reset values
   localparam logic [7:0] SWOCC_C1_RESET = 8'h04;
   localparam logic [7:0] SWOCC_C2_RESET = 8'h00;
   localparam logic [7:0] SWOCC_TRIM_RESET = 8'h00;
   localparam logic [4:0] SWOCC_COARSE_RESET = 5'h00;
   // Filter time constants
   localparam logic [5:0] SWOCC_TC_8 = 6'h08;
   localparam logic [5:0] SWOCC_TC_16 = 6'h10;
   localparam logic [5:0] SWOCC_TC_32 = 6'h20;
   // Recovery clock frequencies in MHz
   localparam logic [6:0] SWOCC_CLK_80 = 7'h50;
   localparam logic [6:0] SWOCC_CLK_40 = 7'h28;
   localparam logic [6:0] SWOCC_CLK_20 = 7'h14;
   localparam logic [6:0] SWOCC_CLK_10 = 7'h0a;
   // Filter select encodings
   typedef enum logic [1:0] {
      SWOCC_FILT_8 = 2'b00,
      SWOCC_FILT_16 = 2'b01,
      SWOCC_FILT_32 = 2'b10,
      SWOCC_FILT_ADAPT = 2'b11
   } swocc_filt_t;
endpackage

// ---- rtl/swocc_filter.sv ----
// Recovery filter time constant selection, fixed or adaptive to edge spacing
`timescale 1ns/1ps
`default_nettype none
module swocc_filter
   import swocc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] filter_constant_choice,
   input wire logic gap_valid,
   input wire logic [3:0] gap_bits,
   output logic [5:0] time_constant_q
);
   swocc_filt_t sel;
   assign sel = swocc_filt_t'(filter_constant_choice);

   // Constant follows the select; adaptive mode updates only on a measured gap
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         time_constant_q <= SWOCC_TC_16;
      end else begin
         case (sel)
            SWOCC_FILT_8: time_constant_q <= SWOCC_TC_8;
            SWOCC_FILT_16: time_constant_q <= SWOCC_TC_16;
            SWOCC_FILT_32: time_constant_q <= SWOCC_TC_32;
            SWOCC_FILT_ADAPT: begin
               // Gaps outside 2..10 bits hold the last constant
               if (gap_valid && gap_bits >= 4'h2 && gap_bits <= 4'h3) begin
                  time_constant_q <= SWOCC_TC_32;
               end else if (gap_valid && gap_bits >= 4'h4 && gap_bits <= 4'h8) begin
                  time_constant_q <= SWOCC_TC_16;
               end else if (gap_valid && gap_bits >= 4'h9 && gap_bits <= 4'ha) begin
                  time_constant_q <= SWOCC_TC_8;
               end
            end
            default: time_constant_q <= SWOCC_TC_16;
         endcase
      end
   end

   a_adapt_short: assert property (@(posedge core_clk) disable iff (!rstn)
      sel == SWOCC_FILT_ADAPT && gap_valid && gap_bits == 4'h2 |=> time_constant_q == SWOCC_TC_32)
      else $error("short gap did not give constant 32");
   a_adapt_long: assert property (@(posedge core_clk) disable iff (!rstn)
      sel == SWOCC_FILT_ADAPT && gap_valid && gap_bits == 4'ha |=> time_constant_q == SWOCC_TC_8)
      else $error("long gap did not give constant 8");
   a_fixed_sel: assert property (@(posedge core_clk) disable iff (!rstn)
      sel == SWOCC_FILT_32 |=> time_constant_q == SWOCC_TC_32)
      else $error("fixed select 32 not applied");
   c_adapt_mid: cover property (@(posedge core_clk) disable iff (!rstn)
      sel == SWOCC_FILT_ADAPT && gap_valid && gap_bits == 4'h6);
endmodule
`default_nettype wire

// ---- rtl/swocc_regs.sv ----
// Selective wake oscillator trim, receiver select and recovery configuration registers
`timescale 1ns/1ps
`default_nettype none
module swocc_regs
   import swocc_pkg::*;
#(
   parameter logic [7:0] TRIM_RESET = SWOCC_TRIM_RESET,
   parameter logic [4:0] COARSE_RESET = SWOCC_COARSE_RESET
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic [6:0] cmd_addr,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] cmd_rdata_q,
   output logic cmd_rvalid_q,
   input wire logic [1:0] trim_enable,
   input wire logic [7:0] calib_value_high,
   input wire logic [7:0] calib_value_low,
   input wire logic gap_valid,
   input wire logic [3:0] gap_bits,
   output logic [7:0] oscillator_adjust,
   output logic [4:0] coarse_adjust,
   output logic [4:0] fine_step,
   output logic wake_receiver_choice,
   output logic recovery_enable,
   output logic [1:0] filter_constant_choice,
   output logic [5:0] filter_time_constant,
   output logic [1:0] recovery_clock_choice,
   output logic [6:0] recovery_clock_mhz_q
);
   // Trim and coarse reset values are parameters: the factory value of the
   // oscillator is not known to this block, so zero stands in for it
   // Stored register state, then combinational decodes
   logic [7:0] trim_q; // Fine trim plus temperature coefficient
   logic [7:0] opt_q; // Receiver select and coarse trim
   logic [7:0] c1_q; // Filter select and recovery enable
   logic [7:0] c2_q; // Recovery clock select
   logic unlocked; // Trim key present
   logic wr_en; // Write command this cycle
   logic [7:0] rd_d; // Read mux

   assign unlocked = (trim_enable == SWOCC_TRIM_KEY);
   assign wr_en = cmd_valid && cmd_write;

   // Trim registers: locked writes are dropped with no error flag
   // Key is sampled on the write edge itself; a key that drops in that cycle blocks it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         trim_q <= TRIM_RESET;
         opt_q <= {3'h0, COARSE_RESET};
      end else if (wr_en && unlocked) begin
         if (cmd_addr == SWOCC_ADDR_TRIM_FINE) begin
            trim_q <= cmd_wdata;
         end
         if (cmd_addr == SWOCC_ADDR_OPTIONS) begin
            // Receiver and coarse trim land together, so software must resend coarse bits
            opt_q <= cmd_wdata & SWOCC_OPT_MASK;
         end
      end
   end

   // Recovery control registers, not key protected
   // Kept free of the key so recovery can be tuned while the trim stays locked
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         c1_q <= SWOCC_C1_RESET;
         c2_q <= SWOCC_C2_RESET;
      end else if (wr_en) begin
         if (cmd_addr == SWOCC_ADDR_CTRL_ONE) begin
            c1_q <= cmd_wdata & SWOCC_C1_MASK;
         end
         if (cmd_addr == SWOCC_ADDR_CTRL_TWO) begin
            c2_q <= cmd_wdata & SWOCC_C2_MASK;
         end
      end
   end

   // Read mux; calibration bytes come straight from the oscillator, unmapped reads zero
   // Reads never need the key, so software can fetch coarse bits before a receiver change
   always_comb begin
      case (cmd_addr)
         SWOCC_ADDR_TRIM_FINE: rd_d = trim_q;
         SWOCC_ADDR_OPTIONS: rd_d = opt_q;
         SWOCC_ADDR_CALIB_HIGH: rd_d = calib_value_high;
         SWOCC_ADDR_CALIB_LOW: rd_d = calib_value_low;
         SWOCC_ADDR_CTRL_ONE: rd_d = c1_q;
         SWOCC_ADDR_CTRL_TWO: rd_d = c2_q;
         default: rd_d = 8'h00;
      endcase
   end

   // Read answer one cycle after the command, held until the next read
   // A write leaves the last read byte standing on the port
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cmd_rdata_q <= 8'h00;
         cmd_rvalid_q <= 1'b0;
      end else begin
         cmd_rvalid_q <= cmd_valid && !cmd_write;
         if (cmd_valid && !cmd_write) begin
            cmd_rdata_q <= rd_d;
         end
      end
   end

   // Recovery clock frequency decode
   // Registered so the recovery logic sees a settled value; it lags the select by a cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         recovery_clock_mhz_q <= SWOCC_CLK_80;
      end else begin
         case (c2_q[1:0])
            2'b00: recovery_clock_mhz_q <= SWOCC_CLK_80;
            2'b01: recovery_clock_mhz_q <= SWOCC_CLK_40;
            2'b10: recovery_clock_mhz_q <= SWOCC_CLK_20;
            2'b11: recovery_clock_mhz_q <= SWOCC_CLK_10;
            default: recovery_clock_mhz_q <= SWOCC_CLK_80;
         endcase
      end
   end

   // Field outputs
   assign oscillator_adjust = trim_q;
   assign fine_step = trim_q[SWOCC_FINE_MSB:0];
   assign coarse_adjust = opt_q[SWOCC_OPT_COARSE_MSB:0];
   assign wake_receiver_choice = opt_q[SWOCC_OPT_RXSEL_BIT];
   assign recovery_enable = c1_q[SWOCC_C1_EN_BIT];
   assign filter_constant_choice = c1_q[SWOCC_C1_FILT_LSB +: 2];
   assign recovery_clock_choice = c2_q[1:0];

   // Filter time constant follows the select
   swocc_filter u_filter (
      .core_clk(core_clk),
      .rstn(rstn),
      .filter_constant_choice(filter_constant_choice),
      .gap_valid(gap_valid),
      .gap_bits(gap_bits),
      .time_constant_q(filter_time_constant)
   );

   // Key protection and write paths
   a_locked_trim: assert property (@(posedge core_clk) disable iff (!rstn)
      !unlocked |=> $stable(trim_q) && $stable(opt_q))
      else $error("trim changed while locked");
   a_unlocked_wr: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_en && unlocked && cmd_addr == SWOCC_ADDR_TRIM_FINE
      |=> oscillator_adjust == $past(cmd_wdata))
      else $error("unlocked trim write lost");
   a_rxsel_write: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_en && unlocked && cmd_addr == SWOCC_ADDR_OPTIONS
      |=> wake_receiver_choice == $past(cmd_wdata[7]) && coarse_adjust == $past(cmd_wdata[4:0]))
      else $error("options write not applied");
   // Read path, field placement and reset defaults
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_rvalid_q |-> (($past(cmd_addr) == SWOCC_ADDR_CTRL_ONE) ? (cmd_rdata_q & 8'hf2) == 8'h00 : 1'b1)
      && (($past(cmd_addr) == SWOCC_ADDR_OPTIONS) ? (cmd_rdata_q & 8'h60) == 8'h00 : 1'b1))
      else $error("reserved bits read nonzero");
   a_calib_read: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && !cmd_write && cmd_addr == SWOCC_ADDR_CALIB_HIGH
      |=> cmd_rvalid_q && cmd_rdata_q == $past(calib_value_high))
      else $error("calibration high read wrong");
   a_enable_wr: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_en && cmd_addr == SWOCC_ADDR_CTRL_ONE |=> recovery_enable == $past(cmd_wdata[0]))
      else $error("recovery enable not written");
   a_clock_map: assert property (@(posedge core_clk) disable iff (!rstn)
      recovery_clock_choice == 2'b11 ##1 recovery_clock_choice == 2'b11
      |-> recovery_clock_mhz_q == SWOCC_CLK_10)
      else $error("clock select 11 not 10 MHz");
   a_filt_default: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(rstn) |-> filter_constant_choice == 2'b01)
      else $error("filter select default wrong");

   // Read path: the low calibration byte and the reserved bits of control two
   a_calib_low: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_valid && !cmd_write && cmd_addr == SWOCC_ADDR_CALIB_LOW
      |=> cmd_rvalid_q && cmd_rdata_q == $past(calib_value_low))
      else $error("calibration low read wrong");
   a_ctrl_two_zero: assert property (@(posedge core_clk) disable iff (!rstn)
      cmd_rvalid_q && $past(cmd_addr) == SWOCC_ADDR_CTRL_TWO
      |-> (cmd_rdata_q & 8'hfc) == 8'h00)
      else $error("control two reserved bits nonzero");

   // Key protection of the receiver bit, and recovery settings that need no key
   a_rxsel_locked: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_en && !unlocked && cmd_addr == SWOCC_ADDR_OPTIONS
      |=> $stable(wake_receiver_choice))
      else $error("receiver choice changed while locked");
   a_ctrl_no_key: assert property (@(posedge core_clk) disable iff (!rstn)
      wr_en && !unlocked && cmd_addr == SWOCC_ADDR_CTRL_TWO
      |=> recovery_clock_choice == $past(cmd_wdata[1:0]))
      else $error("clock select write lost without key");
   a_clock_decode: assert property (@(posedge core_clk) disable iff (!rstn)
      ($past(recovery_clock_choice) != 2'b00 || recovery_clock_mhz_q == SWOCC_CLK_80)
      && ($past(recovery_clock_choice) != 2'b01 || recovery_clock_mhz_q == SWOCC_CLK_40)
      && ($past(recovery_clock_choice) != 2'b10 || recovery_clock_mhz_q == SWOCC_CLK_20))
      else $error("clock select decode wrong");

   // Scenarios worth seeing
   c_unlock_write: cover property (@(posedge core_clk) disable iff (!rstn)
      wr_en && unlocked && cmd_addr == SWOCC_ADDR_OPTIONS);
   c_locked_write: cover property (@(posedge core_clk) disable iff (!rstn)
      wr_en && !unlocked && cmd_addr == SWOCC_ADDR_TRIM_FINE);
   c_adapt_on: cover property (@(posedge core_clk) disable iff (!rstn)
      filter_constant_choice == 2'b11 && recovery_enable);
   c_clock_slow: cover property (@(posedge core_clk) disable iff (!rstn)
      recovery_clock_choice == 2'b11 && recovery_enable);
endmodule
`default_nettype wire

// ---- verification/swocc_regs_test.sv ----
// Self-checking bench for the selective wake trim and recovery register bank
`timescale 1ns/1ps
`default_nettype none
module swocc_regs_test;
   import swocc_pkg::*;
   // One row: key, write address and data, then read address and expected byte
   typedef struct {
      logic [1:0] key;
      logic [6:0] wa;
      logic [7:0] wd;
      logic [6:0] ra;
      logic [7:0] ex;
   } swocc_row_t;
   logic core_clk, rstn, cmd_valid, cmd_write, gap_valid, cmd_rvalid_q;
   logic wake_receiver_choice, recovery_enable;
   logic [6:0] cmd_addr, recovery_clock_mhz_q;
   logic [7:0] cmd_wdata, cmd_rdata_q, oscillator_adjust;
   logic [1:0] trim_enable, filter_constant_choice, recovery_clock_choice;
   logic [7:0] calib_value_high = 8'ha5; // Fixed calibration bytes, easy to tell apart
   logic [7:0] calib_value_low = 8'h3c;
   logic [3:0] gap_bits;
   logic [4:0] coarse_adjust, fine_step;
   logic [5:0] filter_time_constant;
   int failures, samples_checked, i;
   // Ordinary cases; order matters, several rows lean on the state left by earlier rows
   swocc_row_t rows [11] = '{'{2'h3, 7'h38, 8'hff, 7'h38, 8'hff}, '{2'h0, 7'h38, 8'h00, 7'h38, 8'hff},
      '{2'h2, 7'h38, 8'h00, 7'h38, 8'hff}, '{2'h3, 7'h39, 8'hff, 7'h39, 8'h9f},
      '{2'h1, 7'h39, 8'h00, 7'h39, 8'h9f}, '{2'h0, 7'h3c, 8'hff, 7'h3c, 8'h0d},
      '{2'h0, 7'h3d, 8'hff, 7'h3d, 8'h03}, '{2'h3, 7'h3a, 8'h55, 7'h3a, 8'ha5},
      '{2'h3, 7'h3b, 8'h55, 7'h3b, 8'h3c}, '{2'h3, 7'h3e, 8'h00, 7'h3d, 8'h03},
      '{2'h3, 7'h39, 8'h00, 7'h39, 8'h00}};
   logic [5:0] fix_tc [3] = '{SWOCC_TC_8, SWOCC_TC_16, SWOCC_TC_32};
   logic [6:0] mhz [4] = '{SWOCC_CLK_80, SWOCC_CLK_40, SWOCC_CLK_20, SWOCC_CLK_10};
   // Gap spacings, out-of-range ones among them, and the constant each should leave
   logic [3:0] gap_in [8] = '{4'h9, 4'hb, 4'h2, 4'h1, 4'h4, 4'ha, 4'h3, 4'h8};
   logic [5:0] gap_tc [8] = '{SWOCC_TC_8, SWOCC_TC_8, SWOCC_TC_32, SWOCC_TC_32, SWOCC_TC_16,
      SWOCC_TC_8, SWOCC_TC_32, SWOCC_TC_16};

   swocc_regs i_dut (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
      .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q), .trim_enable(trim_enable),
      .calib_value_high(calib_value_high), .calib_value_low(calib_value_low),
      .gap_valid(gap_valid), .gap_bits(gap_bits), .oscillator_adjust(oscillator_adjust),
      .coarse_adjust(coarse_adjust), .fine_step(fine_step),
      .wake_receiver_choice(wake_receiver_choice), .recovery_enable(recovery_enable),
      .filter_constant_choice(filter_constant_choice),
      .filter_time_constant(filter_time_constant),
      .recovery_clock_choice(recovery_clock_choice),
      .recovery_clock_mhz_q(recovery_clock_mhz_q));

   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Compare one byte and count it
   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts, verdict and end of run
   task print_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One write; the extra edge keeps the strobe from toggling twice in one step
   task wr(input logic [1:0] key, input logic [6:0] a, input logic [7:0] d);
      trim_enable = key;
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      @(negedge core_clk);
   endtask

   // One read; the answer is awaited under a bound, not forever
   task rd(input logic [6:0] a, input logic [7:0] e);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_write = 1'b0;
      cmd_addr = a;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      while (cmd_rvalid_q !== 1'b1 && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      if (cmd_rvalid_q !== 1'b1) begin
         failures++;
         $display("[ERR] %0t ns: read answer never came", $time);
         print_verdict();
      end
      check(cmd_rdata_q, e);
      @(negedge core_clk);
   endtask

   // Main sequence, all inputs moved on the falling edge
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 7'h00;
      cmd_wdata = 8'h00;
      trim_enable = 2'h0;
      gap_valid = 1'b0;
      gap_bits = 4'h0;
      failures = 0;
      samples_checked = 0;
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      foreach (rows[r]) begin
         wr(rows[r].key, rows[r].wa, rows[r].wd);
         rd(rows[r].ra, rows[r].ex);
      end
      // Fine trim alone; temperature bits are read first and written back unchanged
      rd(SWOCC_ADDR_TRIM_FINE, 8'hff);
      wr(2'h3, SWOCC_ADDR_TRIM_FINE, 8'hfa);
      check({3'h0, fine_step}, 8'h1a);
      check(oscillator_adjust, 8'hfa);
      // Receiver change keeps the coarse trim that was read back first
      wr(2'h3, SWOCC_ADDR_OPTIONS, 8'h15);
      rd(SWOCC_ADDR_OPTIONS, 8'h15);
      wr(2'h3, SWOCC_ADDR_OPTIONS, 8'h95);
      check({7'h0, wake_receiver_choice}, 8'h01);
      check({3'h0, coarse_adjust}, 8'h15);
      // Fixed filter selects with recovery enabled
      for (i = 0; i < 3; i++) begin
         wr(2'h0, SWOCC_ADDR_CTRL_ONE, {4'h0, i[1:0], 2'b01});
         check({6'h0, filter_constant_choice}, {6'h0, i[1:0]});
         check({2'h0, filter_time_constant}, {2'h0, fix_tc[i]});
         check({7'h0, recovery_enable}, 8'h01);
      end
      // Adaptive select, recovery off
      wr(2'h0, SWOCC_ADDR_CTRL_ONE, 8'h0c);
      check({7'h0, recovery_enable}, 8'h00);
      check({6'h0, filter_constant_choice}, 8'h03);
      for (i = 0; i < 8; i++) begin
         gap_valid = 1'b1;
         gap_bits = gap_in[i];
         @(negedge core_clk);
         gap_valid = 1'b0;
         check({2'h0, filter_time_constant}, {2'h0, gap_tc[i]});
         @(negedge core_clk);
      end
      // Every recovery clock choice
      for (i = 0; i < 4; i++) begin
         wr(2'h0, SWOCC_ADDR_CTRL_TWO, {6'h0, i[1:0]});
         check({6'h0, recovery_clock_choice}, {6'h0, i[1:0]});
         check({1'h0, recovery_clock_mhz_q}, {1'h0, mhz[i]});
      end
      // Write and read of the same register on consecutive edges
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_addr = SWOCC_ADDR_CTRL_ONE;
      cmd_wdata = 8'h05;
      @(negedge core_clk);
      cmd_write = 1'b0;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      check({7'h0, cmd_rvalid_q}, 8'h01);
      check(cmd_rdata_q, 8'h05);
      @(negedge core_clk);
      // Reset in mid-run restores the defaults
      rstn = 1'b0;
      @(negedge core_clk);
      check({2'h0, filter_time_constant}, {2'h0, SWOCC_TC_16});
      check({1'h0, recovery_clock_mhz_q}, {1'h0, SWOCC_CLK_80});
      rstn = 1'b1;
      @(negedge core_clk);
      check(oscillator_adjust, SWOCC_TRIM_RESET);
      check({6'h0, filter_constant_choice}, 8'h01);
      check({6'h0, recovery_clock_choice}, 8'h00);
      rd(SWOCC_ADDR_CTRL_ONE, SWOCC_C1_RESET);
      rd(SWOCC_ADDR_CTRL_TWO, SWOCC_C2_RESET);
      rd(SWOCC_ADDR_OPTIONS, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
